/* File: common/irq_unit_pkg.sv */
// constants and types shared by the interrupt priority unit
package irq_unit_pkg;

    // ====================================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0]  OPTION_OFFSET      = 8'hc8;
    localparam logic [7:0]  STATUS_OFFSET      = 8'hcc;
    localparam logic [7:0]  OPTION_RESET       = 8'h00;
    localparam int          OPT_LEVEL_BIT      = 6;
    localparam int          OPT_POLARITY_BIT   = 5;
    localparam int          OPT_ENABLE_BIT     = 4;
    localparam logic [7:0]  OPTION_WRITE_MASK  = 8'h70;

    // ====================================================================
    // status register fields
    localparam int          ST_MODE_LSB        = 0;
    localparam int          ST_NMI_BIT         = 2;
    localparam int          ST_MASKABLE_LSB    = 3;
    localparam int          ST_WINNER_BIT      = 7;

    // ====================================================================
    // pins on the two external vectors
    localparam int          PORT_A_PINS        = 4;
    localparam int          PORT_B_PINS        = 5;

    // ====================================================================
    // vector addresses (low byte of each pair)
    localparam logic [11:0] VEC_RESET          = 12'hffe;
    localparam logic [11:0] VEC_NMI            = 12'hffc;
    localparam logic [11:0] VEC_PORT_A         = 12'hff6;
    localparam logic [11:0] VEC_PORT_B         = 12'hff4;
    localparam logic [11:0] VEC_TIMER          = 12'hff2;
    localparam logic [11:0] VEC_CONVERTER      = 12'hff0;

    // ====================================================================
    // response time, in cpu cycles and external clocks per cpu cycle
    localparam int          RESP_MIN_CPU       = 6;
    localparam int          RESP_MAX_CPU       = 11;
    localparam int          CLKS_PER_CPU       = 13;
    localparam int          RESP_MIN_CLKS      = RESP_MIN_CPU * CLKS_PER_CPU;
    localparam int          RESP_MAX_CLKS      = RESP_MAX_CPU * CLKS_PER_CPU;
    localparam logic [7:0]  RESP_COUNT_LOAD    = 8'(RESP_MIN_CLKS);

    // ====================================================================
    // core execution mode
    typedef enum logic [1:0] {
        mode_normal,
        mode_irq,
        mode_nmi
    } core_mode_t;

    localparam core_mode_t  MODE_RESET         = mode_nmi;

endpackage : irq_unit_pkg

/* File: core/irq_priority_unit.sv */
// interrupt latching, arbitration and context switch control for the core
//
// What this block does
// - reset pre-empts all; nmi pre-empts maskable only
// - no maskable nesting; vector one highest, four lowest
// - all sources wake wait; converter cannot wake stop
// - falling nmi pin edge requests regardless of enable
// - nmi request latched, cleared when nmi routine starts
// - peripheral flag needs global and own enable
// - peripheral requests on vectors three, four; software clears
// - external vectors load only when event and enabled
// - option bit 6 picks vector one edge or level
// - vector two edge only; bit 5 picks polarity
// - edge latch cleared at routine start; one kept
// - level mode stores nothing; sampled at instruction end
// - option bit 4 masks or allows all maskable sources
// - disabled nmi still serviced but wakes nothing
// - switching vector two to rising latches once spuriously
// - resting active vector two pin masks other pins
// - low pin mode change latches on vector two when rising
// - accept: swap flags, push pc, inhibit, clear, load
// - return restores interrupted routine and its flags
// - maskable request during zero option load keeps normal flags
// - routine ready six cpu cycles after load, always the shortest response
// - fixed vector addresses; converter cannot exit stop
// - events latch while disabled, served once enabled
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module irq_priority_unit (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [7:0]                            paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic                                  nmi_pin,
    input  wire logic [irq_unit_pkg::PORT_A_PINS-1:0]  port_a_pins,
    input  wire logic [irq_unit_pkg::PORT_B_PINS-1:0]  port_b_pins,
    input  wire logic [irq_unit_pkg::PORT_A_PINS-1:0]  port_a_irq_en,
    input  wire logic [irq_unit_pkg::PORT_B_PINS-1:0]  port_b_irq_en,
    input  wire logic                                  timer_underflow_flag,
    input  wire logic                                  timer_irq_en,
    input  wire logic                                  conv_done_flag,
    input  wire logic                                  conv_irq_en,
    input  wire logic                                  instr_done,
    input  wire logic                                  return_from_irq,
    input  wire logic                                  zero_option_load,
    output logic                                       irq_winner,
    output logic      [11:0]                           vector_addr,
    output logic                                       push_pc,
    output logic                                       load_vector,
    output logic                                       maskable_inhibit,
    output logic                                       irq_flags_sel,
    output logic                                       nmi_flags_sel,
    output logic                                       routine_ready,
    output logic                                       wake_wait,
    output logic                                       wake_stop
);

    localparam int PINS = irq_unit_pkg::PORT_A_PINS + irq_unit_pkg::PORT_B_PINS + 1;

    // ====================================================================
    // pin synchronisers
    logic [PINS-1:0] pin_sync1_ff;
    logic [PINS-1:0] pin_sync2_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync1_ff <= '1;
            pin_sync2_ff <= '1;
        end else begin
            pin_sync1_ff <= {nmi_pin, port_b_pins, port_a_pins};
            pin_sync2_ff <= pin_sync1_ff;
        end
    end
    logic                                 nmi_sync;
    logic [irq_unit_pkg::PORT_A_PINS-1:0] pa_sync;
    logic [irq_unit_pkg::PORT_B_PINS-1:0] pb_sync;
    assign pa_sync  = pin_sync2_ff[irq_unit_pkg::PORT_A_PINS-1:0];
    assign pb_sync  = pin_sync2_ff[PINS-2:irq_unit_pkg::PORT_A_PINS];
    assign nmi_sync = pin_sync2_ff[PINS-1];

    // ====================================================================
    // option register and apb slave
    logic [7:0] option_ff;
    logic       pready_ff;
    logic       pslverr_ff;
    logic [31:0] prdata_ff;
    logic [7:0] status_word;
    logic       setup_phase;
    logic       mapped;
    logic       wr_option;
    assign setup_phase = psel & ~penable;
    assign mapped      = (paddr == irq_unit_pkg::OPTION_OFFSET) |
                         (paddr == irq_unit_pkg::STATUS_OFFSET);
    assign wr_option   = psel & penable & pready_ff & pwrite &
                         (paddr == irq_unit_pkg::OPTION_OFFSET);
    // reserved option bits are dropped, only the three control bits stick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_ff <= irq_unit_pkg::OPTION_RESET;
        end else if (wr_option) begin
            option_ff <= pwdata[7:0] & irq_unit_pkg::OPTION_WRITE_MASK;
        end
    end

    // one wait-free access phase; option reads as zero since write only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup_phase;
            pslverr_ff <= setup_phase & ~mapped;
            if (setup_phase && !pwrite && paddr == irq_unit_pkg::STATUS_OFFSET) begin
                prdata_ff <= {24'h00_0000, status_word};
            end else begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end
    logic level_mode;
    logic rising_mode;
    logic global_en;
    assign level_mode  = option_ff[irq_unit_pkg::OPT_LEVEL_BIT];
    assign rising_mode = option_ff[irq_unit_pkg::OPT_POLARITY_BIT];
    assign global_en   = option_ff[irq_unit_pkg::OPT_ENABLE_BIT];

    // ====================================================================
    // external vector sensing
    logic                                 v1_trig;
    logic                                 v1_low_now;
    logic                                 v2_trig;
    logic                                 v2_cfg_set;
    logic [irq_unit_pkg::PORT_B_PINS-1:0] pb_en_prev_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pb_en_prev_ff <= '0;
        end else begin
            pb_en_prev_ff <= port_b_irq_en;
        end
    end
    // disabled pins rest high, so any enabled low pin holds the line
    assign v1_trig    = &(pa_sync | ~port_a_irq_en);
    assign v1_low_now = |(~pa_sync & port_a_irq_en);

    // wired combine lets a resting pin mask edges elsewhere; the
    // polarity inversion also fakes an edge when rising is selected
    assign v2_trig    = rising_mode ? ~(|(pb_sync & port_b_irq_en))
                                    : &(pb_sync | ~port_b_irq_en);
    assign v2_cfg_set = rising_mode & (|(pb_en_prev_ff & ~port_b_irq_en & ~pb_sync));

    // ====================================================================
    // request latches
    logic nmi_pend;
    logic v1_pend;
    logic v2_pend;
    logic clr_nmi;
    logic clr_v1;
    logic clr_v2;
    request_latch u_nmi_latch (.pclk(pclk), .presetn(presetn), .trig_level(nmi_sync),
        .set_extra(1'b0), .hold_en(1'b1), .clear(clr_nmi), .pending(nmi_pend));
    request_latch u_v1_latch (.pclk(pclk), .presetn(presetn), .trig_level(v1_trig),
        .set_extra(1'b0), .hold_en(~level_mode), .clear(clr_v1), .pending(v1_pend));
    request_latch u_v2_latch (.pclk(pclk), .presetn(presetn), .trig_level(v2_trig),
        .set_extra(v2_cfg_set), .hold_en(1'b1), .clear(clr_v2), .pending(v2_pend));

    // ====================================================================
    // arbitration
    irq_unit_pkg::core_mode_t mode_ff;
    logic       nmi_over_irq_ff;
    logic [3:0] mask_req;
    logic       mask_ok;
    logic       nmi_take;
    logic       mask_take;
    logic [11:0] win_vec;
    // peripheral flags stay set until software clears them at the source
    assign mask_req[0] = level_mode ? v1_low_now : v1_pend;
    assign mask_req[1] = v2_pend;
    assign mask_req[2] = timer_underflow_flag & timer_irq_en;
    assign mask_req[3] = conv_done_flag & conv_irq_en;

    // events stay latched while disabled and win once enabled
    assign mask_ok   = (mode_ff == irq_unit_pkg::mode_normal) & global_en;
    assign nmi_take  = nmi_pend & (mode_ff != irq_unit_pkg::mode_nmi);
    assign mask_take = mask_ok & (|mask_req) & ~nmi_take;
    assign win_vec   = nmi_take    ? irq_unit_pkg::VEC_NMI :
                       mask_req[0] ? irq_unit_pkg::VEC_PORT_A :
                       mask_req[1] ? irq_unit_pkg::VEC_PORT_B :
                       mask_req[2] ? irq_unit_pkg::VEC_TIMER : irq_unit_pkg::VEC_CONVERTER;
    logic accept;
    assign accept  = instr_done & (nmi_take | mask_take);
    assign clr_nmi = instr_done & nmi_take;
    assign clr_v1  = instr_done & mask_take & mask_req[0];
    assign clr_v2  = instr_done & mask_take & ~mask_req[0] & mask_req[1];

    // ====================================================================
    // core mode and flag pair selection
    logic irq_flags_ff;
    logic nmi_flags_ff;

    // reset enters nmi mode so the start-up code cannot be interrupted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff         <= irq_unit_pkg::MODE_RESET;
            nmi_over_irq_ff <= 1'b0;
            irq_flags_ff    <= 1'b0;
            nmi_flags_ff    <= 1'b1;
        end else if (accept && nmi_take) begin
            mode_ff         <= irq_unit_pkg::mode_nmi;
            nmi_over_irq_ff <= (mode_ff == irq_unit_pkg::mode_irq);
            nmi_flags_ff    <= 1'b1;
        end else if (accept) begin
            mode_ff         <= irq_unit_pkg::mode_irq;
            irq_flags_ff    <= ~zero_option_load;
        end else if (return_from_irq) begin
            case (mode_ff)
                irq_unit_pkg::mode_nmi: begin
                    mode_ff      <= nmi_over_irq_ff ? irq_unit_pkg::mode_irq
                                                    : irq_unit_pkg::mode_normal;
                    nmi_flags_ff <= 1'b0;
                    nmi_over_irq_ff <= 1'b0;
                end
                irq_unit_pkg::mode_irq: begin
                    mode_ff      <= irq_unit_pkg::mode_normal;
                    irq_flags_ff <= 1'b0;
                end
                default: begin
                    mode_ff      <= irq_unit_pkg::mode_normal;
                end
            endcase
        end
    end

    // ====================================================================
    // core strobes, vector and response timer
    logic        winner_ff;
    logic [11:0] vector_ff;
    logic        push_pc_ff;
    logic        load_vector_ff;
    logic        inhibit_ff;
    logic [7:0]  resp_cnt_ff;
    logic        ready_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            winner_ff      <= 1'b0;
            vector_ff      <= irq_unit_pkg::VEC_RESET;
            push_pc_ff     <= 1'b0;
            load_vector_ff <= 1'b0;
            inhibit_ff     <= 1'b1;
        end else begin
            winner_ff      <= nmi_take | mask_take;
            if (nmi_take || mask_take) begin
                vector_ff  <= win_vec;
            end
            push_pc_ff     <= accept;
            load_vector_ff <= accept;
            inhibit_ff     <= accept | (mode_ff != irq_unit_pkg::mode_normal &&
                                        !(return_from_irq && mode_ff == irq_unit_pkg::mode_irq));
        end
    end

    // a fixed shortest response; the core may stretch it toward the longest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_cnt_ff <= 8'h00;
            ready_ff    <= 1'b0;
        end else begin
            if (accept) begin
                resp_cnt_ff <= irq_unit_pkg::RESP_COUNT_LOAD;
            end else if (resp_cnt_ff != 8'h00) begin
                resp_cnt_ff <= resp_cnt_ff - 8'h01;
            end
            ready_ff <= (resp_cnt_ff == 8'h01) & ~accept;
        end
    end

    // ====================================================================
    // wake-up requests
    logic wake_wait_ff;
    logic wake_stop_ff;

    // disabled state wakes nothing, not even nmi
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_wait_ff <= 1'b0;
            wake_stop_ff <= 1'b0;
        end else begin
            wake_wait_ff <= global_en & (nmi_pend | (|mask_req));
            wake_stop_ff <= global_en & (nmi_pend | (|mask_req[2:0]));
        end
    end

    assign status_word = {winner_ff, mask_req, nmi_pend, mode_ff};

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign irq_winner       = winner_ff;
    assign vector_addr      = vector_ff;
    assign push_pc          = push_pc_ff;
    assign load_vector      = load_vector_ff;
    assign maskable_inhibit = inhibit_ff;
    assign irq_flags_sel    = irq_flags_ff;
    assign nmi_flags_sel    = nmi_flags_ff;
    assign routine_ready    = ready_ff;
    assign wake_wait        = wake_wait_ff;
    assign wake_stop        = wake_stop_ff;

    // ====================================================================
    // checks
    // age since the last vector load; a counter instead of a long repetition
    logic [7:0] since_load_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_load_ff <= 8'h00;
        end else if (load_vector_ff) begin
            since_load_ff <= 8'h01;
        end else if (since_load_ff != 8'h00 && since_load_ff != 8'hff) begin
            since_load_ff <= since_load_ff + 8'h01;
        end
    end
    chk_nmi_preempts: assert property (@(posedge pclk) disable iff (!presetn)
        instr_done && nmi_take |=> mode_ff == irq_unit_pkg::mode_nmi && vector_ff == 12'hffc)
        else $error("nmi not taken at instruction end");
    chk_no_nesting: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mode_ff == irq_unit_pkg::mode_irq) |->
        $past(mode_ff) == irq_unit_pkg::mode_normal || $past(nmi_over_irq_ff))
        else $error("maskable routine nested");
    chk_v1_first: assert property (@(posedge pclk) disable iff (!presetn)
        instr_done && mask_take && mask_req[0] |=> vector_ff == 12'hff6 && load_vector_ff)
        else $error("vector one lost priority");
    chk_conv_no_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !nmi_pend && mask_req == 4'b1000 |=> !wake_stop_ff)
        else $error("converter woke from stop");
    chk_nmi_latched: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(nmi_sync) |=> nmi_pend)
        else $error("nmi edge not latched");
    chk_disabled_mask: assert property (@(posedge pclk) disable iff (!presetn)
        instr_done && !global_en && !nmi_take |=> !load_vector_ff)
        else $error("maskable taken while disabled");
    chk_no_wake_off: assert property (@(posedge pclk) disable iff (!presetn)
        !global_en |=> !wake_wait_ff && !wake_stop_ff)
        else $error("wake while disabled");
    chk_resp_time: assert property (@(posedge pclk) disable iff (!presetn)
        ready_ff |-> since_load_ff >= 8'(irq_unit_pkg::RESP_MIN_CLKS) &&
                     since_load_ff <= 8'(irq_unit_pkg::RESP_MAX_CLKS))
        else $error("routine ready not on time");
    chk_quirk_flags: assert property (@(posedge pclk) disable iff (!presetn)
        accept && !nmi_take && zero_option_load |=> !irq_flags_ff && mode_ff == irq_unit_pkg::mode_irq)
        else $error("flags switched during zero option load");
    chk_return: assert property (@(posedge pclk) disable iff (!presetn)
        return_from_irq && !accept && mode_ff == irq_unit_pkg::mode_irq
        |=> mode_ff == irq_unit_pkg::mode_normal && !irq_flags_ff)
        else $error("return did not restore normal mode");

endmodule : irq_priority_unit

`default_nettype wire

/* File: core/request_latch.sv */
// single request latch with falling-edge detect on its trigger level
`timescale 1ns/1ns
`default_nettype none

module request_latch (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic trig_level,
    input  wire logic set_extra,
    input  wire logic hold_en,
    input  wire logic clear,
    output logic      pending
);

    logic prev_ff;
    logic pend_ff;
    logic set_now;

    // ====================================================================
    // edge detect and latch
    // idle level is high, so a trigger low at release counts as an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b1;
        end else begin
            prev_ff <= trig_level;
        end
    end

    assign set_now = (prev_ff & ~trig_level) | set_extra;

    // one bit only, so further edges while pending are absorbed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= hold_en & (set_now | (pend_ff & ~clear));
        end
    end

    assign pending = pend_ff;

endmodule : request_latch

`default_nettype wire

/* File: test/core_model.sv */
// processor core model: instruction boundaries and returns
`timescale 1ns/1ns
`default_nettype none

module core_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    input  wire logic ret_req,
    input  wire logic routine_ready,
    output logic      instr_done,
    output logic      return_from_irq
);
    // ====================================================================
    // boundaries
    logic [1:0] cnt_ff;

    // a boundary every fourth clock keeps arbitration busy but legal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff     <= 2'h0;
            instr_done <= 1'b0;
        end else begin
            cnt_ff     <= cnt_ff + 2'h1;
            instr_done <= run && (cnt_ff == 2'h3);
        end
    end

    // every routine ends with a return once it is ready to run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            return_from_irq <= 1'b0;
        end else begin
            return_from_irq <= ret_req | routine_ready;
        end
    end
endmodule : core_model
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the interrupt priority unit
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic        pready, pslverr, e, nmi_pin = 1'b1, run = 1'b0, ret_req = 1'b0;
    logic [3:0]  port_a_pins = 4'hf, port_a_irq_en = 4'h0;
    logic [4:0]  port_b_pins = 5'h1f, port_b_irq_en = 5'h00;
    logic        timer_underflow_flag = 1'b0, timer_irq_en = 1'b0, zero_option_load = 1'b0;
    logic        conv_done_flag = 1'b0, conv_irq_en = 1'b0, instr_done, return_from_irq;
    logic        irq_winner, push_pc, load_vector, maskable_inhibit, irq_flags_sel;
    logic        nmi_flags_sel, routine_ready, wake_wait, wake_stop;
    logic [11:0] vector_addr;
    int          err_total = 0, checked = 0;

    always #4 pclk = ~pclk;

    irq_priority_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .nmi_pin, .port_a_pins, .port_b_pins, .port_a_irq_en,
        .port_b_irq_en, .timer_underflow_flag, .timer_irq_en, .conv_done_flag, .conv_irq_en,
        .instr_done, .return_from_irq, .zero_option_load, .irq_winner, .vector_addr, .push_pc,
        .load_vector, .maskable_inhibit, .irq_flags_sel, .nmi_flags_sel, .routine_ready,
        .wake_wait, .wake_stop);
    core_model u_core (.pclk, .presetn, .run, .ret_req, .routine_ready, .instr_done,
        .return_from_irq);

    // ====================================================================
    // tasks
    task complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    // a wait that runs out ends the run as a failure
    task bound(input int n);
        if (n >= 300) begin
            err_total++;
            complete_run();
        end
    endtask : bound

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 300);
        bound(n);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task accept(input logic [11:0] v, input logic nmi);
        int n;
        n = 0;
        do begin @(posedge pclk); n++; end while (load_vector !== 1'b1 && n < 300);
        bound(n);
        chk("vector", v, vector_addr);
        chk("push", 1, push_pc);
        chk("nmi pair", nmi, nmi_flags_sel);
        chk("irq pair", !nmi && !zero_option_load, irq_flags_sel);
        chk("inhibit", 1, maskable_inhibit);
        n = 0;
        do begin @(posedge pclk); n++; end while (routine_ready !== 1'b1 && n < 300);
        bound(n);
        chk("response", irq_unit_pkg::RESP_MIN_CLKS, n);
    endtask : accept

    // ====================================================================
    // sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset vector", 12'hffe, vector_addr);
        chk("reset mode", 1, nmi_flags_sel);
        apb(1'b0, 8'hc8, 32'h0000_0000);
        chk("option read", 0, q);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("slverr", 1, e);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("inhibit", 0, maskable_inhibit);
        $display("test reset done");
        conv_done_flag <= 1'b1;
        conv_irq_en    <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("masked winner", 0, irq_winner);
        apb(1'b1, 8'hc8, 32'h0000_0010);
        repeat (3) @(posedge pclk);
        chk("wait wake", 1, wake_wait);
        chk("stop wake", 0, wake_stop);
        apb(1'b0, 8'hcc, 32'h0000_0000);
        chk("status", 32'h0000_00c0, q);
        timer_underflow_flag <= 1'b1;
        timer_irq_en         <= 1'b1;
        port_a_irq_en        <= 4'h1;
        port_a_pins          <= 4'he;
        repeat (8) @(posedge pclk);
        chk("stop wake", 1, wake_stop);
        run <= 1'b1;
        accept(12'hff6, 1'b0);
        accept(12'hff2, 1'b0);
        timer_underflow_flag <= 1'b0;
        accept(12'hff0, 1'b0);
        conv_done_flag <= 1'b0;
        $display("test priority done");
        apb(1'b1, 8'hc8, 32'h0000_0000);
        nmi_pin <= 1'b0;
        accept(12'hffc, 1'b1);
        nmi_pin <= 1'b1;
        $display("test nmi done");
        port_b_pins <= 5'h1e;
        apb(1'b1, 8'hc8, 32'h0000_0010);
        port_b_irq_en <= 5'h01;
        zero_option_load <= 1'b1;
        accept(12'hff4, 1'b0);
        zero_option_load <= 1'b0;
        $display("test vector two done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
